//--- sdtsc_pkg.sv
// Constants, command codes and state types of the command checker
// Summary of operation
// - Per-bank command decoding only when clock enable high previous and current cycle.
// - Legality judged per bank; bank address picks which bank's state applies.
// - Precharge to precharging or idle bank is no-op; precharging ends after period.
// - While one bank precharges, another bank may still be precharged.
// - Recovering bank accepts write; other commands to it are illegal.
// - Self refresh exits on enable rise with deselect or no-op; else illegal.
// - Power down exits on enable rise, idle after exit interval; low keeps it.
// - Enable falling with all idle: refresh code enters self refresh, no-op power down.
// - Any bank state with enable low last cycle is treated as power down.
// - Otherwise, enable high both cycles means normal per-state command table.
`default_nettype none
package sdtsc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 4;
    localparam int BA_W      = 2;
    localparam int CNT_W     = 8;
    typedef logic [CNT_W-1:0] sdtsc_cnt_t;

    // ------------------------------------------------------------
    // Timing in ns and derived cycle counts, rounded up
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS             = 4;
    localparam int PRECHARGE_PERIOD_NS       = 20;
    localparam int ROW_TO_COL_DELAY_NS       = 20;
    localparam int WRITE_RECOVERY_TIME_NS    = 15;
    localparam int REFRESH_CYCLE_NS          = 75;
    localparam int MODE_SET_NS               = 12;
    localparam int POWERDOWN_EXIT_INTERVAL_NS = 10;
    localparam int SELF_REFRESH_EXIT_NS      = 80;

    localparam sdtsc_cnt_t PRECHARGE_CYC = sdtsc_cnt_t'(
        (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdtsc_cnt_t ROW_TO_COL_CYC = sdtsc_cnt_t'(
        (ROW_TO_COL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdtsc_cnt_t WRITE_RECOVERY_CYC = sdtsc_cnt_t'(
        (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdtsc_cnt_t REFRESH_CYC = sdtsc_cnt_t'(
        (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdtsc_cnt_t MODE_SET_CYC = sdtsc_cnt_t'(
        (MODE_SET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdtsc_cnt_t PD_EXIT_CYC = sdtsc_cnt_t'(
        (POWERDOWN_EXIT_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdtsc_cnt_t SR_EXIT_CYC = sdtsc_cnt_t'(
        (SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam sdtsc_cnt_t CNT_ZERO = sdtsc_cnt_t'(0);
    localparam sdtsc_cnt_t CNT_ONE  = sdtsc_cnt_t'(1);

    // ------------------------------------------------------------
    // Command codes on row strobe, column strobe, write enable
    // ------------------------------------------------------------
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_RD  = 3'h5;
    localparam logic [2:0] CMD_WR  = 3'h4;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_MODE_REG_SET = 3'h0;

    localparam logic CKE_PREV_RST = 1'b0;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BK_IDLE         = 3'b000,
        BK_PRECHARGING  = 3'b001,
        BK_ACTIVATING   = 3'b010,
        BK_ACTIVE       = 3'b011,
        BK_RECOVERING   = 3'b100
    } sdtsc_bank_e;

    typedef enum logic [2:0] {
        PW_NORMAL     = 3'b000,
        PW_REFRESHING = 3'b001,
        PW_MODE_SET   = 3'b010,
        PW_PDOWN      = 3'b011,
        PW_PD_EXIT    = 3'b100,
        PW_SREF       = 3'b101,
        PW_SR_EXIT    = 3'b110
    } sdtsc_pwr_e;

endpackage : sdtsc_pkg
`default_nettype wire

//--- sdtsc_cmd_check.sv
// Command legality and power-state tracking of the memory device
`default_nettype none
module sdtsc_cmd_check
    import sdtsc_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic                   cke,
    input  wire logic                   csN,
    input  wire logic                   rasN,
    input  wire logic                   casN,
    input  wire logic                   weN,
    input  wire logic [BA_W-1:0]        bankAddr,
    input  wire logic                   autoPreFlag,
    output wire logic [NUM_BANKS*3-1:0] bankState,
    output var  logic [2:0]             powerState,
    output var  logic                   allIdle_r,
    output var  logic                   illegalCmd_r,
    output var  logic                   cmdTaken_r,
    output var  logic                   inputsEnabled_r,
    output var  logic                   exitBusy_r
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sdtsc_bank_e bank_r    [NUM_BANKS];
    sdtsc_bank_e bank_nxt  [NUM_BANKS];
    sdtsc_cnt_t  bankCnt_r [NUM_BANKS];
    sdtsc_cnt_t  bankCnt_nxt [NUM_BANKS];
    logic [NUM_BANKS-1:0] bankBad;
    logic [NUM_BANKS-1:0] bankIdle;
    sdtsc_pwr_e  pwr_r;
    sdtsc_pwr_e  pwr_nxt;
    sdtsc_cnt_t  gCnt_r;
    sdtsc_cnt_t  gCnt_nxt;
    logic        ckePrev_r;
    logic        pwrBad;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire logic [2:0] cmdCode  = {rasN, casN, weN};
    wire logic       isNop    = csN | (cmdCode == CMD_NOP);
    wire logic       ckeBoth  = ckePrev_r & cke;
    wire logic       inNormal = (pwr_r == PW_NORMAL);
    wire logic       cmdLive  = inNormal & ckeBoth & ~isNop;
    wire logic       isBst    = cmdLive & (cmdCode == CMD_BST);
    wire logic       isRd     = cmdLive & (cmdCode == CMD_RD);
    wire logic       isWr     = cmdLive & (cmdCode == CMD_WR);
    wire logic       isAct    = cmdLive & (cmdCode == CMD_ACT);
    wire logic       isPre    = cmdLive & (cmdCode == CMD_PRE);
    wire logic       isRef    = cmdLive & (cmdCode == CMD_REF);
    wire logic       isModeSet = cmdLive & (cmdCode == CMD_MODE_REG_SET);
    wire logic       preAll   = isPre & autoPreFlag;
    wire logic       allIdle  = &bankIdle;
    wire logic       refModeBad = (isRef | isModeSet) & ~allIdle;
    wire logic       illegalNow = (|bankBad) | refModeBad | pwrBad;
    wire logic       gLast    = (gCnt_r == CNT_ONE);
    wire sdtsc_cnt_t gDec     = (gCnt_r != CNT_ZERO) ? gCnt_r - CNT_ONE : CNT_ZERO;
    wire logic       srExitOk = ~(pwr_r == PW_SREF) | (cke & isNop);

    // ------------------------------------------------------------
    // Per-bank state and interval counters
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_BANKS; i++) begin : g_bank
        wire logic sel   = (bankAddr == BA_W'(i));
        wire logic last  = (bankCnt_r[i] == CNT_ONE);
        wire logic selPre = (sel & isPre) | preAll;

        assign bankIdle[i] = (bank_r[i] == BK_IDLE);
        assign bankState[3*i +: 3] = bank_r[i];

        always_comb begin
            bank_nxt[i]    = bank_r[i];
            bankCnt_nxt[i] = (bankCnt_r[i] != CNT_ZERO) ? bankCnt_r[i] - CNT_ONE : CNT_ZERO;
            bankBad[i]     = 1'b0;
            case (bank_r[i])
                BK_IDLE: begin
                    if (sel & isAct) begin
                        bank_nxt[i]    = BK_ACTIVATING;
                        bankCnt_nxt[i] = ROW_TO_COL_CYC;
                    end else if (sel & (isRd | isWr | isBst)) begin
                        bankBad[i] = 1'b1;
                    end
                end
                BK_PRECHARGING: begin
                    if (last) begin
                        bank_nxt[i] = BK_IDLE;
                    end
                    if (sel & (isAct | isRd | isWr | isBst)) begin
                        bankBad[i] = 1'b1;
                    end
                end
                BK_ACTIVATING: begin
                    if (last) begin
                        bank_nxt[i] = BK_ACTIVE;
                    end
                    if ((sel & (isAct | isRd | isWr | isBst | isPre)) | preAll) begin
                        bankBad[i] = 1'b1;
                    end
                end
                BK_ACTIVE: begin
                    if (sel & isAct) begin
                        bankBad[i] = 1'b1;
                    end else if (sel & isWr) begin
                        bank_nxt[i]    = BK_RECOVERING;
                        bankCnt_nxt[i] = WRITE_RECOVERY_CYC;
                    end else if (selPre) begin
                        bank_nxt[i]    = BK_PRECHARGING;
                        bankCnt_nxt[i] = PRECHARGE_CYC;
                    end
                end
                BK_RECOVERING: begin
                    if (sel & isWr) begin
                        bankCnt_nxt[i] = WRITE_RECOVERY_CYC;
                    end else if (last) begin
                        bank_nxt[i] = BK_ACTIVE;
                    end
                    if ((sel & (isBst | isRd | isAct | isPre)) | preAll) begin
                        bankBad[i] = 1'b1;
                    end
                end
                default: begin
                    bank_nxt[i] = BK_IDLE;
                end
            endcase
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                bank_r[i]    <= BK_IDLE;
                bankCnt_r[i] <= CNT_ZERO;
            end else begin
                bank_r[i]    <= bank_nxt[i];
                bankCnt_r[i] <= bankCnt_nxt[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Power and device-wide transient states
    // ------------------------------------------------------------
    always_comb begin
        pwr_nxt  = pwr_r;
        gCnt_nxt = gDec;
        pwrBad   = 1'b0;
        case (pwr_r)
            PW_NORMAL: begin
                if (!ckePrev_r) begin
                    pwr_nxt = PW_PDOWN;
                end else if (!cke) begin
                    if (!allIdle) begin
                        pwrBad = 1'b1;
                    end else if (!csN && cmdCode == CMD_REF) begin
                        pwr_nxt = PW_SREF;
                    end else if (isNop) begin
                        pwr_nxt = PW_PDOWN;
                    end else begin
                        pwrBad = 1'b1;
                    end
                end else if (isRef & allIdle) begin
                    pwr_nxt  = PW_REFRESHING;
                    gCnt_nxt = REFRESH_CYC;
                end else if (isModeSet & allIdle) begin
                    pwr_nxt  = PW_MODE_SET;
                    gCnt_nxt = MODE_SET_CYC;
                end
            end
            PW_REFRESHING, PW_MODE_SET: begin
                pwrBad = ~isNop;
                if (gLast) begin
                    pwr_nxt = PW_NORMAL;
                end
            end
            PW_PDOWN: begin
                if (cke) begin
                    pwr_nxt  = PW_PD_EXIT;
                    gCnt_nxt = PD_EXIT_CYC;
                end
            end
            PW_SREF: begin
                if (cke) begin
                    if (isNop) begin
                        pwr_nxt  = PW_SR_EXIT;
                        gCnt_nxt = SR_EXIT_CYC;
                    end else begin
                        pwrBad = 1'b1;
                    end
                end
            end
            PW_PD_EXIT, PW_SR_EXIT: begin
                pwrBad = ~isNop;
                if (gLast) begin
                    pwr_nxt = PW_NORMAL;
                end
            end
            default: begin
                pwr_nxt = PW_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwr_r     <= PW_NORMAL;
            gCnt_r    <= CNT_ZERO;
            ckePrev_r <= CKE_PREV_RST;
        end else begin
            pwr_r     <= pwr_nxt;
            gCnt_r    <= gCnt_nxt;
            ckePrev_r <= cke;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            powerState      <= PW_NORMAL;
            allIdle_r       <= 1'b1;
            illegalCmd_r    <= 1'b0;
            cmdTaken_r      <= 1'b0;
            inputsEnabled_r <= 1'b1;
            exitBusy_r      <= 1'b0;
        end else begin
            powerState      <= pwr_nxt;
            allIdle_r       <= allIdle;
            illegalCmd_r    <= illegalNow;
            cmdTaken_r      <= cmdLive & ~illegalNow;
            inputsEnabled_r <= (pwr_nxt != PW_SREF) & srExitOk;
            exitBusy_r      <= (pwr_nxt == PW_PD_EXIT) | (pwr_nxt == PW_SR_EXIT);
        end
    end

endmodule : sdtsc_cmd_check
`default_nettype wire

//--- sdtsc_cmd_check_sva.sv
// Port assertions of the command checker
`default_nettype none
module sdtsc_cmd_check_sva
    import sdtsc_pkg::*;
(
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic                   cke,
    input wire logic                   csN,
    input wire logic                   rasN,
    input wire logic                   casN,
    input wire logic                   weN,
    input wire logic [BA_W-1:0]        bankAddr,
    input wire logic                   autoPreFlag,
    input wire logic [NUM_BANKS*3-1:0] bankState,
    input wire logic [2:0]             powerState,
    input wire logic                   allIdle_r,
    input wire logic                   illegalCmd_r,
    input wire logic                   cmdTaken_r,
    input wire logic                   inputsEnabled_r,
    input wire logic                   exitBusy_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------
    // Properties
    // --------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic ckePrev_r;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ckePrev_r <= CKE_PREV_RST;
        end else begin
            ckePrev_r <= cke;
        end
    end
    wire logic [2:0] code = {rasN, casN, weN};
    wire logic [2:0] tgt  = bankState[3*bankAddr+:3];
    wire logic       take = ckePrev_r && cke && !csN && code != CMD_NOP && powerState == PW_NORMAL;
    property p_cke_low; !(cke && ckePrev_r) |=> !cmdTaken_r; endproperty
    a_cke_low: assert property (p_cke_low) else $error("command taken with enable low");
    property p_pre_idle; take && code == CMD_PRE && !autoPreFlag && bankAddr == 2'h1
        && bankState[5:3] == BK_IDLE |=> bankState[5:3] == BK_IDLE && !illegalCmd_r; endproperty
    a_pre_idle: assert property (p_pre_idle) else $error("precharge to idle bank acted");
    property p_act; take && code == CMD_ACT && bankAddr == 2'h0 && bankState[2:0] == BK_IDLE
        |=> (bankState[2:0] == BK_ACTIVATING)[*5] ##1 bankState[2:0] == BK_ACTIVE; endproperty
    a_act: assert property (p_act) else $error("activate timing wrong");
    property p_wr; take && code == CMD_WR && tgt inside {BK_ACTIVE, BK_RECOVERING}
        |=> cmdTaken_r && !illegalCmd_r; endproperty
    a_wr: assert property (p_wr) else $error("write refused");
    property p_rec; take && code != CMD_WR && tgt == BK_RECOVERING |=> illegalCmd_r; endproperty
    a_rec: assert property (p_rec) else $error("recovering bank took command");
    property p_ref; take && code == CMD_REF && bankState != '0
        |=> illegalCmd_r && powerState == PW_NORMAL; endproperty
    a_ref: assert property (p_ref) else $error("refresh with busy bank");
    property p_busy; cke && !csN && code != CMD_NOP && powerState == PW_REFRESHING
        |=> illegalCmd_r; endproperty
    a_busy: assert property (p_busy) else $error("command during refresh not flagged");
    property p_pd_in; powerState == PW_NORMAL && bankState == '0 && ckePrev_r && !cke && csN
        |=> powerState == PW_PDOWN; endproperty
    a_pd_in: assert property (p_pd_in) else $error("power down not entered");
    property p_pd_out; powerState == PW_PDOWN && cke
        |=> (powerState == PW_PD_EXIT && exitBusy_r)[*3] ##1 powerState == PW_NORMAL; endproperty
    a_pd_out: assert property (p_pd_out) else $error("power down exit wrong");
    property p_sr_bad; powerState == PW_SREF && cke && !csN && code != CMD_NOP
        |=> illegalCmd_r && powerState == PW_SREF && !inputsEnabled_r; endproperty
    a_sr_bad: assert property (p_sr_bad) else $error("bad self refresh exit taken");
    property p_pre_all; take && code == CMD_PRE && autoPreFlag && bankState[2:0] == BK_ACTIVE
        |=> bankState[2:0] == BK_PRECHARGING; endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all missed bank");
    property p_idle_flag; bankState != '0 |=> !allIdle_r; endproperty
    a_idle_flag: assert property (p_idle_flag) else $error("idle flag with busy bank");
endmodule : sdtsc_cmd_check_sva
bind sdtsc_cmd_check sdtsc_cmd_check_sva sdtsc_cmd_check_sva_i (
    .clk_sys, .rst, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .autoPreFlag, .bankState,
    .powerState, .allIdle_r, .illegalCmd_r, .cmdTaken_r, .inputsEnabled_r, .exitBusy_r
);
`default_nettype wire

//--- sdtsc_ctrl_model.sv
// Memory controller model driving the command pins
`default_nettype none
module sdtsc_ctrl_model
    import sdtsc_pkg::*;
(
    input  wire logic            clk_sys,
    output var  logic            cke,
    output var  logic            csN,
    output var  logic [2:0]      code,
    output var  logic [BA_W-1:0] bankAddr,
    output var  logic            autoPreFlag
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------
    // Command driver
    // --------------------
    initial begin
        cke = 1'b1;
        csN = 1'b1;
        code = CMD_NOP;
        bankAddr = '0;
        autoPreFlag = 1'b0;
    end
    // One command cycle, then deselect with lines inverted; caller spaces by bank timers
    task automatic send(input logic k, input logic s, input logic [2:0] c,
                        input logic [BA_W-1:0] b, input logic ap, input logic ka);
        @(negedge clk_sys);
        cke = k;
        csN = s;
        code = c;
        bankAddr = b;
        autoPreFlag = ap;
        @(negedge clk_sys);
        cke = ka;
        csN = 1'b1;
        code = ~c;
        bankAddr = ~b;
        autoPreFlag = ~ap;
    endtask : send
endmodule : sdtsc_ctrl_model
`default_nettype wire

//--- tb_top.sv
// Testbench of the command checker
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module tb_top
    import sdtsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------
    // Bench
    // --------------------
    logic                   clk_sys;
    logic                   rst;
    logic                   cke;
    logic                   csN;
    logic [2:0]             code;
    logic [BA_W-1:0]        bankAddr;
    logic                   autoPreFlag;
    logic [NUM_BANKS*3-1:0] bankState;
    logic [2:0]             powerState;
    logic                   allIdle_r;
    logic                   illegalCmd_r;
    logic                   cmdTaken_r;
    logic                   inputsEnabled_r;
    logic                   exitBusy_r;
    int                     n_fail = 0;
    int                     n_compared = 0;
    sdtsc_ctrl_model ctrl_i (.clk_sys, .cke, .csN, .code, .bankAddr, .autoPreFlag);
    sdtsc_cmd_check sdtsc_cmd_check_i (.clk_sys, .rst, .cke, .csN, .rasN(code[2]),
        .casN(code[1]), .weN(code[0]), .bankAddr, .autoPreFlag, .bankState, .powerState,
        .allIdle_r, .illegalCmd_r, .cmdTaken_r, .inputsEnabled_r, .exitBusy_r);
    function automatic logic [2:0] bk(input int i);
        return bankState[3*i+:3];
    endfunction : bk
    task automatic cmd(input logic [2:0] c, input logic [BA_W-1:0] b);
        ctrl_i.send(1'b1, 1'b0, c, b, 1'b0, 1'b1);
    endtask : cmd
    task automatic wt(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt
    task automatic s_bank();
        cmd(CMD_PRE, 2'h1);
        `CHK({illegalCmd_r, bk(1)}, 4'h0)
        cmd(CMD_ACT, 2'h0);
        `CHK({cmdTaken_r, bk(0)}, {1'b1, BK_ACTIVATING})
        cmd(CMD_ACT, 2'h1);
        wt(5);
        `CHK(bankState[5:0], 6'h1b)
        cmd(CMD_WR, 2'h0);
        `CHK(bk(0), BK_RECOVERING)
        cmd(CMD_WR, 2'h0);
        `CHK(illegalCmd_r, 1'b0)
        cmd(CMD_PRE, 2'h0);
        `CHK({illegalCmd_r, bk(0)}, {1'b1, BK_RECOVERING})
        wt(3);
        `CHK(bk(0), BK_ACTIVE)
        cmd(CMD_PRE, 2'h0);
        `CHK(bk(0), BK_PRECHARGING)
        cmd(CMD_RD, 2'h0);
        `CHK(illegalCmd_r, 1'b1)
        cmd(CMD_PRE, 2'h1);
        `CHK({illegalCmd_r, bankState[5:0]}, 7'h09)
        wt(6);
        `CHK(bankState, 12'h000)
    endtask : s_bank
    task automatic s_pre_all();
        cmd(CMD_ACT, 2'h0);
        wt(5);
        cmd(CMD_ACT, 2'h1);
        ctrl_i.send(1'b1, 1'b0, CMD_PRE, 2'h3, 1'b1, 1'b1);
        `CHK({illegalCmd_r, bankState[5:0]}, 7'h51)
        wt(3);
        `CHK(allIdle_r, 1'b0)
        ctrl_i.send(1'b1, 1'b0, CMD_PRE, 2'h3, 1'b1, 1'b1);
        `CHK({illegalCmd_r, bankState[5:0]}, 7'h08)
        wt(6);
        `CHK({allIdle_r, bankState}, 13'h1000)
    endtask : s_pre_all
    task automatic s_refresh();
        cmd(CMD_ACT, 2'h2);
        cmd(CMD_REF, 2'h0);
        `CHK({illegalCmd_r, powerState}, {1'b1, PW_NORMAL})
        wt(5);
        cmd(CMD_MODE_REG_SET, 2'h0);
        `CHK(illegalCmd_r, 1'b1)
        cmd(CMD_PRE, 2'h2);
        wt(6);
        cmd(CMD_REF, 2'h0);
        `CHK(powerState, PW_REFRESHING)
        cmd(CMD_ACT, 2'h3);
        `CHK(illegalCmd_r, 1'b1)
        wt(17);
        `CHK(powerState, PW_NORMAL)
        cmd(CMD_MODE_REG_SET, 2'h0);
        `CHK(powerState, PW_MODE_SET)
        cmd(CMD_BST, 2'h0);
        `CHK(illegalCmd_r, 1'b1)
        wt(1);
        `CHK(powerState, PW_NORMAL)
    endtask : s_refresh
    task automatic s_power();
        ctrl_i.send(1'b0, 1'b1, CMD_NOP, 2'h0, 1'b0, 1'b0);
        `CHK(powerState, PW_PDOWN)
        wt(4);
        `CHK(powerState, PW_PDOWN)
        ctrl_i.send(1'b1, 1'b0, CMD_ACT, 2'h0, 1'b0, 1'b1);
        `CHK({exitBusy_r, powerState}, {1'b1, PW_PD_EXIT})
        wt(3);
        `CHK(powerState, PW_NORMAL)
        ctrl_i.send(1'b0, 1'b0, CMD_REF, 2'h0, 1'b0, 1'b0);
        `CHK({inputsEnabled_r, powerState}, {1'b0, PW_SREF})
        ctrl_i.send(1'b1, 1'b0, CMD_WR, 2'h0, 1'b0, 1'b0);
        `CHK({illegalCmd_r, powerState}, {1'b1, PW_SREF})
        ctrl_i.send(1'b1, 1'b0, CMD_NOP, 2'h0, 1'b0, 1'b1);
        `CHK({inputsEnabled_r, powerState}, {1'b1, PW_SR_EXIT})
        wt(20);
        `CHK(powerState, PW_NORMAL)
        ctrl_i.send(1'b0, 1'b0, CMD_RD, 2'h0, 1'b0, 1'b1);
        `CHK(illegalCmd_r, 1'b1)
    endtask : s_power
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        rst = 1'b1;
        wt(16);
        rst = 1'b0;
        wt(8);
        s_bank();
        s_pre_all();
        s_refresh();
        s_power();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
